// >>> hbg_bridge_ctrl.sv
// Top of the H-bridge gate control block: truth table, fault forcing, registers and interrupt.
// Behaviour
// R1 - Enable low puts the block in standby: gates resistive, diagnostic released.
// R2 - Host waits 50 us after raising enable before relying on bridge.
// R3 - Host holds direction and PWM high at wake-up, braking, before standby.
// R4 - Without faults gates follow truth table of PWM and direction.
// R5 - In normal driving states the diagnostic output stays high.
// R6 - Overtemperature forces all gates to sink, serial line off, diagnostic low.
// R7 - Supply overvoltage forces all gates to sink, serial line off, diagnostic low.
// R8 - Supply undervoltage keeps all gates sinking and diagnostic low.
// R9 - High-side gate off when its node stays low past detection time.
// R10 - Low-side gate off when its node stays high past detection time.
// R11 - Short-latched gate stays off until direction or PWM changes.
// R12 - Short shutdown affects only the shorted transistor; others keep driving.
// R13 - Diagnostic is low whenever any fault is present, in real time.
// R14 - Input change turns affected gate off at once, on after delay.
// R15 - Cross-conduction delay is programmable, default 0.69 times R times C.
// R16 - Delay and detection times are clock counters set by configuration.
// R17 - Global faults override short handling and force all gates to sink.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module hbg_bridge_ctrl (
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic enable_in,
    input wire logic direction_in,
    input wire logic pwm_in,
    input wire logic overtemp_fault_in,
    input wire logic supply_high_fault_in,
    input wire logic supply_low_fault_in,
    input wire logic bridge_node_a_high_in,
    input wire logic bridge_node_b_high_in,
    input wire hbg_pkg::hbg_bus_t bus_in,
    output logic [hbg_pkg::CW-1:0] rdata_out,
    output logic upper_gate_a_out,
    output logic lower_gate_a_out,
    output logic upper_gate_b_out,
    output logic lower_gate_b_out,
    output logic gates_active_out,
    output logic fault_flag_n_out,
    output logic fault_flag_n_oe_n_out,
    output logic kline_off_out,
    output logic irq_out
);
    import hbg_pkg::*;

    // ------------------------------------------------------------
    // State and derived terms
    // ------------------------------------------------------------
    hbg_top_t s_q;
    hbg_top_t s_d;

    logic [2:0] glob;
    logic glob_any;
    logic kill;
    logic chg;
    logic [3:0] dem;
    logic [3:0] bad;
    logic [3:0] gates;
    logic [3:0] sc_lat;
    logic [NEV-1:0] ev;
    logic [NEV-1:0] w1c;
    logic any_fault;

    assign glob = {supply_low_fault_in, supply_high_fault_in, overtemp_fault_in};
    assign glob_any = |glob;

    // R17 global faults first
    assign kill = !enable_in || glob_any;

    // R14 edge of direction or PWM
    assign chg = (direction_in != s_q.dir) || (pwm_in != s_q.pwm);

    // ------------------------------------------------------------
    // Truth table
    // ------------------------------------------------------------
    // R4 demanded gates
    assign dem[G_UA] = !pwm_in && direction_in;
    assign dem[G_LA] = pwm_in || !direction_in;
    assign dem[G_UB] = !pwm_in && !direction_in;
    assign dem[G_LB] = pwm_in || direction_in;

    // R9 high side sees node low
    assign bad[G_UA] = !bridge_node_a_high_in;
    assign bad[G_UB] = !bridge_node_b_high_in;
    // R10 low side sees node high
    assign bad[G_LA] = bridge_node_a_high_in;
    assign bad[G_LB] = bridge_node_b_high_in;

    // ------------------------------------------------------------
    // Gate channels
    // ------------------------------------------------------------
    // R12 one latch per transistor
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ch
            hbg_gate_ch u_ch (
                .clk_in(core_clk_in),
                .rstn_in(rstn_in),
                .demand_in(dem[gi]),
                .kill_in(kill),
                .change_in(chg),
                .node_bad_in(bad[gi]),
                .dly_cyc_in(s_q.dly),
                .scd_cyc_in(s_q.scd),
                .gate_on_out(gates[gi]),
                .short_out(sc_lat[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Events and register access
    // ------------------------------------------------------------
    assign ev = {sc_lat & ~s_q.sc_prev, glob & ~s_q.glob_prev};
    assign w1c = (bus_in.wr && bus_in.addr == A_IST) ? bus_in.wdata[NEV-1:0] : '0;

    always_comb begin
        s_d = s_q;
        s_d.dir = direction_in;
        s_d.pwm = pwm_in;
        s_d.glob_prev = glob;
        s_d.sc_prev = sc_lat;
        // A new event outranks a clear written in the same cycle.
        s_d.ist = (s_q.ist & ~w1c) | ev;
        if (bus_in.wr) begin
            unique case (bus_in.addr)
                // R15 programmable delay
                A_DLY: s_d.dly = bus_in.wdata;
                // R16 detection count
                A_SCD: s_d.scd = bus_in.wdata;
                A_IMSK: s_d.imsk = bus_in.wdata[NEV-1:0];
                default: ;
            endcase
        end
        s_d.rdata = '0;
        if (bus_in.rd) begin
            unique case (bus_in.addr)
                A_DLY: s_d.rdata = s_q.dly;
                A_SCD: s_d.rdata = s_q.scd;
                A_LIVE: s_d.rdata = CW'({enable_in, glob, sc_lat, gates});
                A_IST: s_d.rdata = CW'(s_q.ist);
                A_IMSK: s_d.rdata = CW'(s_q.imsk);
                default: s_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_q <= '0;
            s_q.dir <= 1'b1;
            s_q.pwm <= 1'b1;
            s_q.dly <= DLY_RST;
            s_q.scd <= SCD_RST;
            s_q.imsk <= IMSK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // R13 any fault pulls low
    assign any_fault = glob_any || (|sc_lat);

    // R1 standby releases pins
    assign gates_active_out = enable_in;
    // R5 R6 R7 R8 diagnostic drive
    assign fault_flag_n_oe_n_out = !(enable_in && any_fault);
    // The pin is open drain, so the driven level is always low.
    assign fault_flag_n_out = 1'b0;
    // R6 R7 serial line off
    assign kline_off_out = enable_in && (overtemp_fault_in || supply_high_fault_in);

    assign upper_gate_a_out = gates[G_UA];
    assign lower_gate_a_out = gates[G_LA];
    assign upper_gate_b_out = gates[G_UB];
    assign lower_gate_b_out = gates[G_LB];
    assign rdata_out = s_q.rdata;
    assign irq_out = |(s_q.ist & s_q.imsk);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_drop;
        enable_in && !glob_any && (dem != 4'hF);
    endsequence

    property p_standby;
        !enable_in |-> !gates_active_out ##1 (gates == 4'h0);
    endproperty
    a_standby: assert property (p_standby) // R1
        else $error("standby left gates active");

    property p_standby_gates;
        !enable_in ##1 !enable_in |-> (gates == 4'h0) && fault_flag_n_oe_n_out;
    endproperty
    a_standby_gates: assert property (p_standby_gates) // R1
        else $error("gate on or diagnostic driven in standby");

    property p_follow;
        s_drop |=> ((gates & ~$past(dem)) == 4'h0);
    endproperty
    a_follow: assert property (p_follow) // R4
        else $error("gate on without demand");

    property p_diag_ok;
        enable_in && !glob_any && (sc_lat == 4'h0) |-> fault_flag_n_oe_n_out;
    endproperty
    a_diag_ok: assert property (p_diag_ok) // R5
        else $error("diagnostic driven low without fault");

    property p_overtemp;
        enable_in && overtemp_fault_in |-> kline_off_out && !fault_flag_n_oe_n_out
            ##1 (gates == 4'h0);
    endproperty
    a_overtemp: assert property (p_overtemp) // R6
        else $error("overtemperature not forcing safe state");

    property p_overvolt;
        enable_in && supply_high_fault_in |-> kline_off_out ##1 (gates == 4'h0);
    endproperty
    a_overvolt: assert property (p_overvolt) // R7
        else $error("overvoltage not forcing safe state");

    property p_undervolt;
        (enable_in && supply_low_fault_in) [*2] |-> (gates == 4'h0) && !fault_flag_n_oe_n_out;
    endproperty
    a_undervolt: assert property (p_undervolt) // R8
        else $error("undervoltage gates not sinking");

    property p_hold;
        (sc_lat != 4'h0) && !chg |=> ((sc_lat & $past(sc_lat)) == $past(sc_lat));
    endproperty
    a_hold: assert property (p_hold) // R11
        else $error("short latch released without input change");

    property p_short_off;
        (sc_lat & gates) == 4'h0;
    endproperty
    a_short_off: assert property (p_short_off) // R12
        else $error("latched gate still on");

    property p_diag_fault;
        enable_in && (sc_lat != 4'h0) |-> !fault_flag_n_oe_n_out;
    endproperty
    a_diag_fault: assert property (p_diag_fault) // R13
        else $error("diagnostic released during short");

    property p_cross;
        !(gates[G_UA] && gates[G_LA]) && !(gates[G_UB] && gates[G_LB]);
    endproperty
    a_cross: assert property (p_cross) // R14
        else $error("both gates of one half bridge on");

    property p_delay;
        (s_q.dly >= CW'(2)) && $rose(gates[G_LA]) |-> $past(dem[G_LA], 2);
    endproperty
    a_delay: assert property (p_delay) // R14
        else $error("gate turned on before delay");

    property p_glob;
        glob_any |=> (gates == 4'h0);
    endproperty
    a_glob: assert property (p_glob) // R17
        else $error("global fault left a gate on");

    property p_release;
        (sc_lat != 4'h0) && chg |=> ((sc_lat & $past(sc_lat)) == 4'h0);
    endproperty
    a_release: assert property (p_release) // R11
        else $error("short latch kept after input change");

    property p_hs_short;
        $rose(sc_lat[G_UA]) |-> $past(gates[G_UA]) && $past(!bridge_node_a_high_in);
    endproperty
    a_hs_short: assert property (p_hs_short) // R9
        else $error("high side latched without low node");

    property p_ls_short;
        $rose(sc_lat[G_LA]) |-> $past(gates[G_LA]) && $past(bridge_node_a_high_in);
    endproperty
    a_ls_short: assert property (p_ls_short) // R10
        else $error("low side latched without high node");

    property p_off_fast;
        enable_in && !dem[G_UB] |=> !gates[G_UB];
    endproperty
    a_off_fast: assert property (p_off_fast) // R14
        else $error("gate not turned off at once");

    property p_event;
        $rose(overtemp_fault_in) |=> s_q.ist[0];
    endproperty
    a_event: assert property (p_event) // R6
        else $error("overtemperature event not recorded");

endmodule // hbg_bridge_ctrl
`default_nettype wire

// >>> hbg_pkg.sv
// Shared constants, register map and carrier types of the H-bridge gate control block.
package hbg_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 100;
    localparam int RPR_OHM = 10000;
    localparam int CPR_PF = 150;
    // Delay of 0.69 * R * C, the RC discharge to half voltage (ratio 2).
    localparam int CCP_NS = (69 * RPR_OHM * CPR_PF) / 100000;
    localparam int CCP_CYC = (CCP_NS + CLK_NS - 1) / CLK_NS;
    localparam int SCD_US = 10;
    localparam int SCD_CYC = (SCD_US * 1000) / CLK_NS;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int CW = 16;
    localparam int AW = 3;
    localparam logic [AW-1:0] A_DLY = 3'h0;
    localparam logic [AW-1:0] A_SCD = 3'h1;
    localparam logic [AW-1:0] A_LIVE = 3'h2;
    localparam logic [AW-1:0] A_IST = 3'h3;
    localparam logic [AW-1:0] A_IMSK = 3'h4;
    localparam logic [CW-1:0] DLY_RST = CW'(CCP_CYC);
    localparam logic [CW-1:0] SCD_RST = CW'(SCD_CYC);

    // Event bits: 0 overtemp, 1 supply high, 2 supply low, 3..6 short per gate.
    localparam int NEV = 7;
    localparam int EV_SC = 3;
    localparam logic [NEV-1:0] IMSK_RST = 7'h00;

    // Gate index order.
    localparam int G_UA = 0;
    localparam int G_LA = 1;
    localparam int G_UB = 2;
    localparam int G_LB = 3;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [CW-1:0] wdata;
        logic wr;
        logic rd;
    } hbg_bus_t;

    typedef struct packed {
        logic on;
        logic lat;
        logic [CW-1:0] dcnt;
        logic [CW-1:0] scnt;
    } hbg_ch_t;

    typedef struct packed {
        logic dir;
        logic pwm;
        logic [2:0] glob_prev;
        logic [3:0] sc_prev;
        logic [NEV-1:0] ist;
        logic [NEV-1:0] imsk;
        logic [CW-1:0] dly;
        logic [CW-1:0] scd;
        logic [CW-1:0] rdata;
    } hbg_top_t;

endpackage

// >>> hbg_gate_ch.sv
// One gate channel: turn-on delay, short detection and short latch.
`timescale 1ns/1ps
`default_nettype none
module hbg_gate_ch (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic demand_in,
    input wire logic kill_in,
    input wire logic change_in,
    input wire logic node_bad_in,
    input wire logic [hbg_pkg::CW-1:0] dly_cyc_in,
    input wire logic [hbg_pkg::CW-1:0] scd_cyc_in,
    output logic gate_on_out,
    output logic short_out
);
    import hbg_pkg::*;

    hbg_ch_t s_q;
    hbg_ch_t s_d;

    always_comb begin
        s_d = s_q;
        // R11 clear on change
        if (change_in) begin
            s_d.lat = 1'b0;
        end
        // R14 off at once
        if (kill_in || !demand_in || s_q.lat) begin
            s_d.on = 1'b0;
            s_d.dcnt = '0;
        end else if (!s_q.on) begin
            // R16 delay counter
            s_d.dcnt = s_q.dcnt + CW'(1);
            if (s_d.dcnt >= dly_cyc_in) begin
                s_d.on = 1'b1;
                s_d.dcnt = '0;
            end
        end
        // R9 R10 short timer
        if (s_q.on && node_bad_in && !kill_in) begin
            s_d.scnt = s_q.scnt + CW'(1);
            // The latch set is evaluated last so it wins over a same-cycle clear.
            if (s_d.scnt >= scd_cyc_in) begin
                s_d.lat = 1'b1;
                s_d.on = 1'b0;
                s_d.scnt = '0;
            end
        end else begin
            s_d.scnt = '0;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign gate_on_out = s_q.on;
    assign short_out = s_q.lat;

endmodule // hbg_gate_ch
`default_nettype wire

// >>> hbg_bridge_model.sv
// Behavioural model of the external MOS bridge as seen by the node comparators.
`timescale 1ns/1ps
`default_nettype none
module hbg_bridge_model (
    input wire logic upper_a_in,
    input wire logic lower_a_in,
    input wire logic upper_b_in,
    input wire logic lower_b_in,
    input wire logic [1:0] short_a_in,
    output logic node_a_high_out,
    output logic node_b_high_out
);
    // ------------------------------------------------------------
    // Node levels
    // ------------------------------------------------------------
    // Code 1 ties the node to ground and code 2 to the supply. With both
    // transistors off, or both on in cross conduction, the sink resistor wins.
    assign node_a_high_out = (short_a_in == 2'h2) |
                             ((short_a_in != 2'h1) & upper_a_in & ~lower_a_in);
    assign node_b_high_out = upper_b_in & ~lower_b_in;
endmodule // hbg_bridge_model
`default_nettype wire

// >>> tb.sv
// Self-checking testbench of the H-bridge gate control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import hbg_pkg::*;
    // Short counts keep the run brief; all timing checks derive from them.
    localparam int DLY = 4;
    localparam int SCD = 6;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic en = 1'b1;
    logic dir = 1'b1;
    logic pwm = 1'b1;
    logic hot = 1'b0;
    logic vhi = 1'b0;
    logic vlo = 1'b0;
    logic [1:0] sh_a = 2'h0;
    hbg_bus_t bus = '0;
    logic [CW-1:0] rdata;
    logic ua, la, ub, lb, act, flag_n, flag_oe_n, kl, irq, na, nb;
    logic [3:0] gv;
    int bad_count = 0;
    int comparisons = 0;
    assign gv = {lb, ub, la, ua};
    always #50 core_clk = ~core_clk;

    hbg_bridge_ctrl hbg_bridge_ctrl_inst (
        .core_clk_in(core_clk),
        .rstn_in(rstn),
        .enable_in(en),
        .direction_in(dir),
        .pwm_in(pwm),
        .overtemp_fault_in(hot),
        .supply_high_fault_in(vhi),
        .supply_low_fault_in(vlo),
        .bridge_node_a_high_in(na),
        .bridge_node_b_high_in(nb),
        .bus_in(bus),
        .rdata_out(rdata),
        .upper_gate_a_out(ua),
        .lower_gate_a_out(la),
        .upper_gate_b_out(ub),
        .lower_gate_b_out(lb),
        .gates_active_out(act),
        .fault_flag_n_out(flag_n),
        .fault_flag_n_oe_n_out(flag_oe_n),
        .kline_off_out(kl),
        .irq_out(irq)
    );

    hbg_bridge_model hbg_bridge_model_inst (
        .upper_a_in(ua),
        .lower_a_in(la),
        .upper_b_in(ub),
        .lower_b_in(lb),
        .short_a_in(sh_a),
        .node_a_high_out(na),
        .node_b_high_out(nb)
    );

    // ------------------------------------------------------------
    // Common tasks
    // ------------------------------------------------------------
    task automatic give_verdict;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [CW-1:0] e, input logic [CW-1:0] got);
        comparisons++;
        if (got !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, got);
        end
    endtask

    task automatic chkb(input string nm, input logic e, input logic got);
        comparisons++;
        if (got !== e) begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", nm, e, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic drv(input logic d, input logic p);
        @(posedge core_clk);
        dir <= d;
        pwm <= p;
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [CW-1:0] d);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [AW-1:0] a, input logic [CW-1:0] e, input string nm);
        @(posedge core_clk);
        bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rd(A_DLY, DLY_RST, "delay reset");
        rd(A_SCD, SCD_RST, "detect reset");
        rd(A_IMSK, '0, "mask reset");
        wr(A_DLY, CW'(DLY));
        wr(A_SCD, CW'(SCD));
        wr(3'h7, 16'hFFFF);
        rd(A_DLY, CW'(DLY), "delay");
        rd(A_SCD, CW'(SCD), "detect");
        rd(3'h7, '0, "unmapped");
        wr(A_IMSK, 16'h007F);
    endtask

    task automatic t_standby;
        drv(1'b1, 1'b1);
        @(posedge core_clk);
        en <= 1'b0;
        cyc(3);
        chkb("active", 1'b0, act);
        chkb("flag released", 1'b1, flag_oe_n);
        chkb("flag level", 1'b0, flag_n);
        chk("gates standby", 16'h0000, {12'h000, gv});
        @(posedge core_clk);
        en <= 1'b1;
        cyc(500);
        chkb("active", 1'b1, act);
    endtask

    task automatic t_truth;
        logic [3:0] e [3];
        e = '{4'hA, 4'h6, 4'h9};
        for (int i = 0; i < 3; i++) begin
            drv(i == 2, i == 0);
            cyc(DLY + 3);
            chk("gates", {12'h000, e[i]}, {12'h000, gv});
            chkb("flag idle", 1'b1, flag_oe_n);
        end
    endtask

    task automatic t_delay;
        drv(1'b0, 1'b1);
        cyc(DLY + 3);
        rd(A_LIVE, 16'h080A, "live");
        wr(A_LIVE, 16'h0000);
        rd(A_LIVE, 16'h080A, "live read only");
        drv(1'b0, 1'b0);
        cyc(2);
        chkb("lower b off", 1'b0, lb);
        chkb("lower a kept", 1'b1, la);
        cyc(DLY - 3);
        chkb("upper b waits", 1'b0, ub);
        cyc(2);
        chkb("upper b on", 1'b1, ub);
    endtask

    task automatic t_global;
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            {vlo, vhi, hot} <= 3'(1 << i);
            cyc(3);
            chk("gates forced", 16'h0000, {12'h000, gv});
            chkb("flag fault", 1'b0, flag_oe_n);
            chkb("line off", i < 2, kl);
            chkb("irq", 1'b1, irq);
            rd(A_IST, CW'(1 << i), "status");
            @(posedge core_clk);
            {vlo, vhi, hot} <= 3'h0;
            wr(A_IST, CW'(1 << i));
            cyc(DLY + 3);
            chkb("irq cleared", 1'b0, irq);
            chk("gates back", 16'h0006, {12'h000, gv});
        end
        wr(A_IMSK, 16'h0000);
        @(posedge core_clk);
        hot <= 1'b1;
        cyc(3);
        chkb("irq masked", 1'b0, irq);
        rd(A_IST, 16'h0001, "status masked");
        @(posedge core_clk);
        hot <= 1'b0;
        wr(A_IST, 16'h0001);
        wr(A_IMSK, 16'h007F);
    endtask

    task automatic t_short(input logic d, input int g, input logic [1:0] code);
        int n;
        int k;
        n = 0;
        k = d ? G_LB : G_UB;
        drv(d, 1'b0);
        cyc(DLY + 3);
        @(posedge core_clk);
        sh_a <= code;
        while (gv[g] === 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        chkb("detect time", 1'b1, n >= SCD && n <= SCD + 1);
        if (n == 20)
            give_verdict();
        chkb("other gate", 1'b1, gv[k]);
        chkb("flag short", 1'b0, flag_oe_n);
        rd(A_IST, CW'(1 << (EV_SC + g)), "short status");
        @(posedge core_clk);
        sh_a <= 2'h0;
        cyc(DLY + 3);
        chkb("latched off", 1'b0, gv[g]);
        drv(d, 1'b1);
        drv(d, 1'b0);
        cyc(DLY + 3);
        chkb("released", 1'b1, gv[g]);
        chkb("flag clear", 1'b1, flag_oe_n);
        wr(A_IST, 16'h007F);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        cyc(500);
        t_regs();
        t_standby();
        t_truth();
        t_delay();
        t_global();
        t_short(1'b1, G_UA, 2'h1);
        t_short(1'b0, G_LA, 2'h2);
        give_verdict();
    end

    // A hang costs at most 20000 cycles before the report.
    initial begin
        #2000000;
        bad_count++;
        give_verdict();
    end
endmodule // tb
`default_nettype wire
